// ===== hw/core_pkg.sv
// Shared constants for the instruction decoder and program memory reader
package core_pkg;
  // Program counter and instruction cycle
  localparam int         PC_W       = 13;
  localparam int         PHASES     = 4;
  localparam logic [1:0] PHASE_LAST = 2'(PHASES - 1);
  // Instruction format prefixes
  localparam logic [1:0] FMT_BYTE = 2'b00;
  localparam logic [1:0] FMT_BIT  = 2'b01;
  localparam logic [1:0] FMT_JUMP = 2'b10;
  localparam logic [1:0] FMT_LIT  = 2'b11;
  // Byte-oriented operation codes
  localparam logic [3:0] OP_MOVWF = 4'h0;
  localparam logic [3:0] OP_CLR   = 4'h1;
  localparam logic [3:0] OP_SUB   = 4'h2;
  localparam logic [3:0] OP_DEC   = 4'h3;
  localparam logic [3:0] OP_IOR   = 4'h4;
  localparam logic [3:0] OP_AND   = 4'h5;
  localparam logic [3:0] OP_XOR   = 4'h6;
  localparam logic [3:0] OP_ADD   = 4'h7;
  localparam logic [3:0] OP_MOV   = 4'h8;
  localparam logic [3:0] OP_COM   = 4'h9;
  localparam logic [3:0] OP_INC   = 4'ha;
  localparam logic [3:0] OP_DECSZ = 4'hb;
  localparam logic [3:0] OP_RRC   = 4'hc;
  localparam logic [3:0] OP_RLC   = 4'hd;
  localparam logic [3:0] OP_SWAP  = 4'he;
  localparam logic [3:0] OP_INCSZ = 4'hf;
  // Bit-oriented sub-codes
  localparam logic [1:0] BIT_CLR = 2'b00;
  localparam logic [1:0] BIT_SET = 2'b01;
  localparam logic [1:0] BIT_SKC = 2'b10;
  localparam logic [1:0] BIT_SKS = 2'b11;
  // Fixed control opcodes
  localparam logic [13:0] OPC_RETURN = 14'h0008;
  localparam logic [13:0] OPC_RETFIE = 14'h0009;
  localparam logic [13:0] OPC_SLEEP  = 14'h0063;
  localparam logic [13:0] OPC_CLRWDT = 14'h0064;
  // File register addresses
  localparam logic [6:0] FA_TIMER0  = 7'h01;
  localparam logic [6:0] FA_PCL     = 7'h02;
  localparam logic [6:0] FA_STATUS  = 7'h03;
  localparam logic [6:0] FA_PORT    = 7'h05;
  localparam logic [6:0] FA_FL_CTRL = 7'h0c;
  localparam logic [6:0] FA_FL_DATL = 7'h0d;
  localparam logic [6:0] FA_FL_DATH = 7'h0e;
  localparam logic [6:0] FA_FL_ADRL = 7'h0f;
  localparam logic [6:0] FA_FL_ADRH = 7'h10;
  // Status and flash control bit positions
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int FL_RD = 0;
  // APB register map and fields
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_PC     = 12'h008;
  localparam int CTRL_RUN  = 0;
  localparam int SR_STBY   = 5;
  localparam int SR_FLBUSY = 6;
  localparam int SR_W_LSB  = 8;
  // Flash read controller states
  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_ARMED = 2'b01,
    FL_FETCH = 2'b10
  } flash_state_t;
endpackage

// ===== hw/core_decode.sv
// Instruction decoder, executor and program memory read controller
//
// How it works
// RQ1: Byte format: 00, opcode, d, address
// RQ2: d=0 writes W, d=1 writes file
// RQ3: Decrement, skip next when zero, no flags
// RQ4: Increment, skip next when zero, no flags
// RQ5: Rotate left through carry, carry only
// RQ6: Rotate right through carry, carry only
// RQ7: OR W with file, zero only
// RQ8: XOR W with file, zero only
// RQ9: Bit test, skip when bit clear
// RQ10: Bit test, skip when bit set
// RQ11: OR literal into W, zero only
// RQ12: Return with literal in W, two cycles
// RQ13: Sleep opcode enters standby, updates flags
// RQ14: Jumps and true tests add a NOP cycle
// RQ15: Port read-modify-write uses pin values
// RQ16: Timer zero write clears assigned prescaler
// RQ17: Instruction cycle is four clocks
// RQ18: Read word at flash address pair
// RQ19: Read strobe bit starts a read
// RQ20: Read takes two cycles, second ignored
// RQ21: Software places two NOPs after strobe; the bench places one NOP, then an OR-literal word in the ignored second slot
// RQ22: Fetched word lands in data pair
// RQ23: Reads ignore code protection
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module core_decode #(
  parameter int STACK_DEPTH = 8
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Program memory port
  output logic      [12:0] prog_addr,
  input  wire logic [13:0] prog_data,
  // I/O port
  input  wire logic [7:0]  port_pins,
  output logic      [7:0]  port_latch,
  // Timer zero prescaler
  input  wire logic        prescaler_assigned,
  output logic             prescaler_clear,
  // Standby
  input  wire logic        wake,
  output logic             standby
);
  localparam int PW  = core_pkg::PC_W;
  localparam int SPW = $clog2(STACK_DEPTH);

  generate
    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad
      $error("STACK_DEPTH must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [1:0]                      phase;
    logic                            run;
    logic                            standby;
    logic                            to;
    logic                            pd;
    logic                            c;
    logic                            dc;
    logic                            z;
    logic                            skip;
    logic                            bubble;
    logic                            rd;
    core_pkg::flash_state_t          fl;
    logic [7:0]                      w;
    logic [PW-1:0]                   pc;
    logic [SPW-1:0]                  sp;
    logic [STACK_DEPTH-1:0][PW-1:0]  stack;
    logic [7:0]                      adr_lo;
    logic [7:0]                      adr_hi;
    logic [7:0]                      dat_lo;
    logic [7:0]                      dat_hi;
    logic [7:0]                      port_latch;
    logic                            prescaler_clear;
    logic [PW-1:0]                   prog_addr;
    logic [31:0]                     prdata;
    logic                            pready;
    logic                            pslverr;
    logic [127:0][7:0]               file;
  } state_t;

  state_t      s;
  state_t      next_s;
  logic [13:0] ins;
  logic [6:0]  fa;
  logic [2:0]  bn;
  logic [7:0]  fv;
  logic [7:0]  opnd;
  logic [7:0]  res;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic        sub;
  logic        exec;
  logic        wr_f;
  logic        wr_w;
  logic        upd_z;
  logic        upd_c;
  logic        upd_dc;
  logic        c_new;
  logic        acc;

  // File register read with special registers mapped in
  function automatic logic [7:0] read_file(input state_t st, input logic [6:0] a,
                                           input logic [7:0] pins);
    logic [7:0] v;
    v = st.file[a];
    case (a)
      core_pkg::FA_PCL: v = st.pc[7:0];
      core_pkg::FA_STATUS: begin
        v = 8'h00;
        v[core_pkg::ST_C]  = st.c;
        v[core_pkg::ST_DC] = st.dc;
        v[core_pkg::ST_Z]  = st.z;
        v[core_pkg::ST_PD] = st.pd;
        v[core_pkg::ST_TO] = st.to;
      end
      core_pkg::FA_PORT: v = pins; // RQ15
      core_pkg::FA_FL_CTRL: begin
        v = 8'h00;
        v[core_pkg::FL_RD] = st.rd;
      end
      core_pkg::FA_FL_DATL: v = st.dat_lo;
      core_pkg::FA_FL_DATH: v = st.dat_hi;
      core_pkg::FA_FL_ADRL: v = st.adr_lo;
      core_pkg::FA_FL_ADRH: v = st.adr_hi;
      default: ;
    endcase
    return v;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    next_s = s;
    ins    = prog_data;
    fa     = ins[6:0]; // RQ1
    bn     = ins[9:7];
    fv     = read_file(s, fa, port_pins);
    opnd   = (ins[13:12] == core_pkg::FMT_LIT) ? ins[7:0] : fv;
    sub    = (ins[13:12] == core_pkg::FMT_BYTE && ins[11:8] == core_pkg::OP_SUB)
          || (ins[13:12] == core_pkg::FMT_LIT && ins[11:9] == 3'b110);
    sum9   = {1'b0, opnd} + {1'b0, sub ? ~s.w : s.w} + {8'h00, sub};
    sum5   = {1'b0, opnd[3:0]} + {1'b0, sub ? ~s.w[3:0] : s.w[3:0]} + {4'h0, sub};
    res    = 8'h00;
    wr_f   = 1'b0;
    wr_w   = 1'b0;
    upd_z  = 1'b0;
    upd_c  = 1'b0;
    upd_dc = 1'b0;
    c_new  = s.c;
    acc    = psel & penable;
    exec   = (s.phase == core_pkg::PHASE_LAST) && s.run && !s.standby; // RQ17
    next_s.phase           = s.phase + 2'd1; // RQ17
    next_s.prescaler_clear = 1'b0;
    next_s.pready          = 1'b0;
    next_s.pslverr         = 1'b0;
    if (s.standby && wake) begin
      next_s.standby = 1'b0;
    end

    // Execute one instruction per instruction cycle
    if (exec) begin
      next_s.pc = s.pc + 1'b1;
      if (s.fl == core_pkg::FL_FETCH) begin
        // Slot taken by the flash word; no protection gating applies
        next_s.dat_lo = ins[7:0]; // RQ22 RQ23
        next_s.dat_hi = {2'b00, ins[13:8]}; // RQ22
        next_s.rd     = 1'b0;
        next_s.fl     = core_pkg::FL_IDLE; // RQ20
        next_s.skip   = 1'b0;
        next_s.bubble = 1'b0;
        if (s.bubble) begin
          next_s.pc = s.pc;
        end
      end else if (s.bubble) begin
        next_s.pc     = s.pc; // RQ14
        next_s.bubble = 1'b0;
      end else if (s.skip) begin
        next_s.skip = 1'b0; // RQ14
      end else if (ins == core_pkg::OPC_SLEEP) begin
        next_s.standby = 1'b1; // RQ13
        next_s.to      = 1'b1;
        next_s.pd      = 1'b0;
      end else if (ins == core_pkg::OPC_CLRWDT) begin
        next_s.to = 1'b1;
        next_s.pd = 1'b1;
      end else if (ins == core_pkg::OPC_RETURN || ins == core_pkg::OPC_RETFIE) begin
        next_s.sp     = s.sp - 1'b1;
        next_s.pc     = s.stack[s.sp - 1'b1];
        next_s.bubble = 1'b1; // RQ14
      end else begin
        case (ins[13:12])
          core_pkg::FMT_BYTE: begin
            wr_f  = ins[7]; // RQ2
            wr_w  = ~ins[7]; // RQ2
            upd_z = 1'b1;
            case (ins[11:8])
              core_pkg::OP_MOVWF: begin
                res   = s.w;
                wr_w  = 1'b0;
                upd_z = 1'b0;
              end
              core_pkg::OP_CLR: res = 8'h00;
              core_pkg::OP_SUB, core_pkg::OP_ADD: begin
                res    = sum9[7:0];
                c_new  = sum9[8];
                upd_c  = 1'b1;
                upd_dc = 1'b1;
              end
              core_pkg::OP_DEC: res = fv - 8'h01;
              core_pkg::OP_IOR: res = s.w | opnd; // RQ7
              core_pkg::OP_AND: res = s.w & opnd;
              core_pkg::OP_XOR: res = s.w ^ opnd; // RQ8
              core_pkg::OP_MOV: res = fv;
              core_pkg::OP_COM: res = ~fv;
              core_pkg::OP_INC: res = fv + 8'h01;
              core_pkg::OP_DECSZ: begin
                res         = fv - 8'h01; // RQ3
                upd_z       = 1'b0;
                next_s.skip = (res == 8'h00); // RQ3
              end
              core_pkg::OP_INCSZ: begin
                res         = fv + 8'h01; // RQ4
                upd_z       = 1'b0;
                next_s.skip = (res == 8'h00); // RQ4
              end
              core_pkg::OP_RRC: begin
                res   = {s.c, fv[7:1]}; // RQ6
                c_new = fv[0];
                upd_c = 1'b1;
                upd_z = 1'b0;
              end
              core_pkg::OP_RLC: begin
                res   = {fv[6:0], s.c}; // RQ5
                c_new = fv[7];
                upd_c = 1'b1;
                upd_z = 1'b0;
              end
              core_pkg::OP_SWAP: begin
                res   = {fv[3:0], fv[7:4]};
                upd_z = 1'b0;
              end
              default: ;
            endcase
          end
          core_pkg::FMT_BIT: begin
            res = fv;
            case (ins[11:10])
              core_pkg::BIT_CLR: begin
                res[bn] = 1'b0;
                wr_f    = 1'b1;
              end
              core_pkg::BIT_SET: begin
                res[bn] = 1'b1;
                wr_f    = 1'b1;
              end
              core_pkg::BIT_SKC: next_s.skip = ~fv[bn]; // RQ9
              core_pkg::BIT_SKS: next_s.skip = fv[bn]; // RQ10
              default: ;
            endcase
          end
          core_pkg::FMT_JUMP: begin
            if (!ins[11]) begin
              next_s.stack[s.sp] = s.pc + 1'b1;
              next_s.sp          = s.sp + 1'b1;
            end
            next_s.pc     = {s.pc[PW-1:11], ins[10:0]};
            next_s.bubble = 1'b1; // RQ14
          end
          default: begin
            wr_w  = 1'b1;
            upd_z = 1'b1;
            casez (ins[11:8])
              4'b00??: begin
                res   = opnd;
                upd_z = 1'b0;
              end
              4'b01??: begin
                res           = opnd; // RQ12
                upd_z         = 1'b0;
                next_s.sp     = s.sp - 1'b1;
                next_s.pc     = s.stack[s.sp - 1'b1];
                next_s.bubble = 1'b1; // RQ12
              end
              4'b1000: res = s.w | opnd; // RQ11
              4'b1001: res = s.w & opnd;
              4'b1010: res = s.w ^ opnd;
              default: begin
                res    = sum9[7:0];
                c_new  = sum9[8];
                upd_c  = 1'b1;
                upd_dc = 1'b1;
              end
            endcase
          end
        endcase
      end

      // Result write-back to W or file space
      if (wr_w) begin
        next_s.w = res; // RQ2
      end
      if (wr_f) begin
        case (fa)
          core_pkg::FA_PCL: begin
            next_s.pc     = {s.pc[PW-1:8], res};
            next_s.bubble = 1'b1; // RQ14
          end
          core_pkg::FA_STATUS: begin
            next_s.c  = res[core_pkg::ST_C];
            next_s.dc = res[core_pkg::ST_DC];
            next_s.z  = res[core_pkg::ST_Z];
          end
          core_pkg::FA_PORT: next_s.port_latch = res; // RQ15
          core_pkg::FA_FL_CTRL: begin
            if (res[core_pkg::FL_RD]) begin
              next_s.rd = 1'b1; // RQ19
            end
          end
          core_pkg::FA_FL_ADRL: next_s.adr_lo = res;
          core_pkg::FA_FL_ADRH: next_s.adr_hi = res;
          core_pkg::FA_FL_DATL, core_pkg::FA_FL_DATH: ;
          core_pkg::FA_TIMER0: begin
            next_s.file[fa]        = res;
            next_s.prescaler_clear = prescaler_assigned; // RQ16
          end
          default: next_s.file[fa] = res;
        endcase
      end

      // Flags after write-back so arithmetic results win
      if (upd_z) begin
        next_s.z = (res == 8'h00);
      end
      if (upd_c) begin
        next_s.c = c_new;
      end
      if (upd_dc) begin
        next_s.dc = sum5[4];
      end

      // Read sequencing: armed cycle runs, next slot is the flash fetch
      if (s.fl == core_pkg::FL_IDLE && next_s.rd && !s.rd) begin
        next_s.fl = core_pkg::FL_ARMED; // RQ19
      end else if (s.fl == core_pkg::FL_ARMED) begin
        next_s.fl = core_pkg::FL_FETCH; // RQ20
      end
      next_s.prog_addr = (next_s.fl == core_pkg::FL_FETCH)
                       ? {next_s.adr_hi[PW-9:0], next_s.adr_lo} // RQ18
                       : next_s.pc;
    end

    // APB slave: answer one cycle into the access phase
    if (acc && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      case (paddr)
        core_pkg::OFS_CTRL: next_s.prdata[core_pkg::CTRL_RUN] = s.run;
        core_pkg::OFS_STATUS: begin
          next_s.prdata[core_pkg::ST_C]      = s.c;
          next_s.prdata[core_pkg::ST_DC]     = s.dc;
          next_s.prdata[core_pkg::ST_Z]      = s.z;
          next_s.prdata[core_pkg::ST_PD]     = s.pd;
          next_s.prdata[core_pkg::ST_TO]     = s.to;
          next_s.prdata[core_pkg::SR_STBY]   = s.standby;
          next_s.prdata[core_pkg::SR_FLBUSY] = (s.fl != core_pkg::FL_IDLE);
          next_s.prdata[core_pkg::SR_W_LSB +: 8] = s.w;
        end
        core_pkg::OFS_PC: next_s.prdata[PW-1:0] = s.pc;
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (acc && s.pready && pwrite && paddr == core_pkg::OFS_CTRL) begin
      next_s.run = pwdata[core_pkg::CTRL_RUN];
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s    <= '0;
      s.to <= 1'b1;
      s.pd <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign prdata          = s.prdata;
  assign pready          = s.pready;
  assign pslverr         = s.pslverr;
  assign prog_addr       = s.prog_addr;
  assign port_latch      = s.port_latch;
  assign prescaler_clear = s.prescaler_clear;
  assign standby         = s.standby;
endmodule

// ===== tb/prog_mem.sv
// Program memory model for the core fetch port, with a slow setting
`timescale 1ns/1ps
module prog_mem (
  // Clock and pacing
  input  wire logic        ref_clk,
  input  wire logic        slow,
  // Fetch port
  input  wire logic [12:0] prog_addr,
  output logic      [13:0] prog_data
);
  logic [13:0] mem [0:8191];
  logic [12:0] seen;
  logic [1:0]  age;
  // Empty store reads as no-operation words
  initial begin
    seen = '0;
    age  = '0;
    for (int i = 0; i < 8192; i++) mem[i] = 14'h0000;
  end
  // Age of the fetch address, so slow mode settles only in the last cycle
  always @(posedge ref_clk) begin
    if (prog_addr != seen) age <= 2'd0;
    else if (age != 2'd3) age <= age + 2'd1;
    seen <= prog_addr;
  end
  // Slow mode shows inverted words until settled; no protection gate on reads
  assign prog_data = (slow && (prog_addr != seen || age < 2'd2)) ? ~mem[prog_addr]
                     : mem[prog_addr];
endmodule

// ===== tb/core_decode_chk.sv
// Checker of bus, fetch, port and standby timing at the core decoder ports
`timescale 1ns/1ps
module core_decode_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // Register bus
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core side
  input wire logic [12:0] prog_addr,
  input wire logic [7:0]  port_latch,
  input wire logic        prescaler_assigned,
  input wire logic        prescaler_clear,
  input wire logic        wake,
  input wire logic        standby
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Hit on one of the three mapped words
  wire mapped = paddr inside {core_pkg::OFS_CTRL, core_pkg::OFS_STATUS, core_pkg::OFS_PC};
  // Bus handshake
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("bus access not answered");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_unmapped_err: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  // Four clocks per instruction cycle
  a_fetch_period: assert property ($changed(prog_addr) |=> $stable(prog_addr)[*3])
    else $error("fetch address moved inside an instruction cycle");
  a_latch_period: assert property ($changed(port_latch) |=> $stable(port_latch)[*3])
    else $error("port latch moved inside an instruction cycle");
  // Prescaler clear only when assigned, as a single pulse
  a_clear_assign: assert property (prescaler_clear |-> $past(prescaler_assigned))
    else $error("prescaler cleared while not assigned");
  a_clear_pulse: assert property (prescaler_clear |=> !prescaler_clear)
    else $error("prescaler clear longer than one cycle");
  // Standby freezes fetch and ends on wake
  a_standby_hold: assert property (standby && $past(standby) |-> $stable(prog_addr))
    else $error("fetch moved in standby");
  a_wake_clears: assert property ($rose(wake) |-> ##[1:4] !standby)
    else $error("standby not left on wake");
  // Main scenarios reached
  c_standby: cover property ($rose(standby));
  c_refused: cover property (pready && pslverr);
  c_clear: cover property (prescaler_clear);
endmodule

bind core_decode core_decode_chk core_decode_chk_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
  .port_latch(port_latch), .prescaler_assigned(prescaler_assigned),
  .prescaler_clear(prescaler_clear), .wake(wake), .standby(standby)
);

// ===== tb/tb.sv
// Self-checking bench running generated programs on the core decoder
`timescale 1ns/1ps
module tb;
  // Design signals
  logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        prescaler_assigned, prescaler_clear, wake, standby, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [12:0] prog_addr;
  logic [13:0] prog_data;
  logic [7:0]  port_pins, port_latch;
  // Bench model state
  int          err_count, cmp_count, pc, n_clr;
  logic [31:0] seed, rd;
  logic        serr, c;
  logic [7:0]  w, last, f20, seen_latch;
  logic [7:0]  exp_q[$], got_q[$];

  core_decode core_decode_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
    .port_pins(port_pins), .port_latch(port_latch),
    .prescaler_assigned(prescaler_assigned), .prescaler_clear(prescaler_clear),
    .wake(wake), .standby(standby)
  );
  prog_mem prog_mem_i (
    .ref_clk(ref_clk), .slow(slow), .prog_addr(prog_addr), .prog_data(prog_data)
  );

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Record latch changes and prescaler clear pulses
  always @(posedge ref_clk) begin
    if (reset_n && port_latch !== seen_latch) got_q.push_back(port_latch);
    if (prescaler_clear === 1'b1) n_clr++;
    seen_latch = port_latch;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus transfer, held until ready is seen
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // Only the watchdog ends a wait that never sees ready
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_sb(input logic v);
    int n;
    n = 0;
    while (standby !== v && n < 4000) begin
      n++;
      @(posedge ref_clk);
    end
    check(32'(standby), 32'(v));
  endtask

  task automatic put(input logic [13:0] op);
    prog_mem_i.mem[pc] = op;
    pc++;
  endtask

  // Expected latch value, kept only when it changes
  task automatic note(input logic [7:0] v);
    if (v != last) exp_q.push_back(v);
    last = v;
  endtask

  task automatic out();
    put(14'h0085);
    note(w);
  endtask

  // Program and its expected results, built side by side
  task automatic build(input logic [7:0] p);
    logic [7:0]  a, k;
    logic [13:0] fw;
    logic [2:0]  bt;
    a = rnd();
    k = rnd();
    fw = 14'({rnd(), rnd()});
    bt = 3'(rnd());
    pc = 0;
    last = 8'h00;
    exp_q.delete();
    got_q.delete();
    put(14'h3000 | 14'(a));
    put(14'h00a0);
    put(14'h3000 | 14'(k));
    put(14'h0420);
    w = a | k;
    out();
    put(14'h06a0);
    f20 = w ^ a;
    put(14'h0820);
    w = f20;
    out();
    put(14'h3881);
    w = w | 8'h81;
    out();
    put(14'h1003);
    c = 1'b0;
    put(14'h0d20);
    {c, w} = {f20, c};
    out();
    put(14'h0c20);
    {w, c} = {c, f20};
    out();
    // Flash word read through the address pair
    put(14'h3001);
    put(14'h0090);
    put(14'h3000 | 14'(k));
    put(14'h008f);
    prog_mem_i.mem[{5'h01, k}] = fw;
    put(14'h140c);
    put(14'h0000);
    put(14'h3808);
    put(14'h080d);
    w = fw[7:0];
    out();
    put(14'h080e);
    w = {2'b00, fw[13:8]};
    out();
    // Port read-modify-write and timer write
    put(14'h1005);
    note(p & 8'hfe);
    put(14'h0805);
    w = p;
    out();
    put(14'h0081);
    // Skips
    put(14'h3001);
    put(14'h00a1);
    w = 8'h01;
    put(14'h0ba1);
    put(14'h3810);
    out();
    put(14'h0ba1);
    put(14'h3820);
    w = w | 8'h20;
    out();
    put(14'h0fa1);
    put(14'h3840);
    out();
    put(14'h1820 | 14'({bt, 7'h00}));
    put(14'h3802);
    if (f20[bt]) w = w | 8'h02;
    out();
    put(14'h1c20 | 14'({bt, 7'h00}));
    put(14'h3804);
    if (!f20[bt]) w = w | 8'h04;
    out();
    // Call into a literal return, then standby
    a = rnd();
    put(14'h2000 | 14'(pc + 4));
    w = a;
    out();
    put(14'h0063);
    put(14'h2800 | 14'(pc));
    put(14'h3400 | 14'(a));
  endtask

  task automatic close_out();
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Two passes: prompt then slow program memory, each from reset
  initial begin
    logic [7:0] pv;
    seed = 32'hec34;
    {reset_n, psel, penable, pwrite, wake, slow} = '0;
    paddr = '0;
    pwdata = '0;
    port_pins = '0;
    prescaler_assigned = 1'b1;
    seen_latch = '0;
    for (int pass = 0; pass < 2; pass++) begin
      reset_n <= 1'b0;
      slow <= pass[0];
      // Second pass leaves the prescaler with another owner
      prescaler_assigned <= !pass[0];
      pv = rnd();
      port_pins <= pv;
      n_clr = 0;
      repeat (16) @(posedge ref_clk);
      // Program loaded after time zero, clear of the store's own start-up fill
      build(pv);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
        apb(1'b0, 12'(i * 4), 32'h0);
        check(32'(serr), 32'(i == 3));
        if (i == 1) check(32'(rd[4:3]), 32'h3);
        if (i == 3) check(rd, 32'h0);
      end
      apb(1'b1, core_pkg::OFS_CTRL, 32'h1);
      apb(1'b0, core_pkg::OFS_CTRL, 32'h0);
      check(rd, 32'h1);
      wait_sb(1'b1);
      apb(1'b0, core_pkg::OFS_STATUS, 32'h0);
      check(32'(rd[15:8]), 32'(w));
      check(32'({rd[5:2], rd[0]}), 32'({4'b1100, c}));
      check(32'(got_q.size()), 32'(exp_q.size()));
      foreach (exp_q[i]) if (i < got_q.size()) check(32'(got_q[i]), 32'(exp_q[i]));
      check(32'(n_clr), 32'(!pass[0]));
      wake <= 1'b1;
      @(posedge ref_clk);
      wait_sb(1'b0);
      wake <= 1'b0;
      $display("Pass %0d done", pass);
    end
    close_out();
  end

  // Watchdog well beyond two short programs
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule
